// ===== logic/wdcrf_pkg.sv
// Constants, state layout and register map of the watchdog supervision block
// What this block does
// - Power-on flag set at power-up; only a software write clears it.
// - Time-out sets the interrupt flag; software and every reset, the watchdog chip reset included, clear it.
// - A watchdog chip reset sets the watchdog-reset flag; software clears it.
// - With reset enable at 0, watchdog activity never touches the reset flag.
// - Power-on and power-fail resets clear the reset flag; external reset keeps it.
// - Writing 1 to reset enable arms the chip reset on time-out.
// - Reset enable clears on power-on reset only; other resets keep it.
// - Writing 1 to restart zeroes the counter; the bit then clears itself.
// - Time-out requests an interrupt; chip reset follows 512 clocks later if enabled.
// - External reset keeps the power-on flag, reset flag, reset enable, irq status and irq mask; it clears the rest.
// - All bits readable; power-on flag, enable, irq flag, restart need unlock.
// - Interval select 11 in clock control bits 7:6 gives the 26-bit count.
// - Enable register bit 4 enables the watchdog irq; bits 7:5 read 1.
// - Priority register bit 4 sets the watchdog irq priority level.
package wdcrf_pkg;
	localparam logic [7:0] ADDR_WD_CTRL = 8'hD8;
	localparam logic [7:0] ADDR_EXT_IRQ_EN = 8'hE8;
	localparam logic [7:0] ADDR_EXT_IRQ_PRI = 8'hF8;
	localparam logic [7:0] ADDR_UNLOCK = 8'hC7;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h8E;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h9A;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h9B;
	localparam int BIT_POWER_ON = 6;
	localparam int BIT_IRQ_FLAG = 3;
	localparam int BIT_RST_FLAG = 2;
	localparam int BIT_RST_EN = 1;
	localparam int BIT_RESTART = 0;
	localparam int BIT_WD_IRQ_EN = 4;
	localparam int BIT_WD_IRQ_PRI = 4;
	localparam int BIT_SEL_LO = 6;
	localparam logic [2:0] EIE_RSVD_ONES = 3'h7;
	localparam logic [7:0] KEY_FIRST = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	localparam int CNT_W = 26;
	localparam int DELAY_W = 10;
	localparam int OPEN_W = 3;
	localparam int EV_W = 3;
	localparam logic [DELAY_W-1:0] RESET_DELAY_CLKS = 10'h200;
	localparam logic [OPEN_W-1:0] UNLOCK_OPEN_CLKS = 3'h4;
	localparam logic [5:0] CLK_CTRL_LOW_RESET = 6'h01;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam int EV_TIMEOUT = 0;
	localparam int EV_CHIP_RST = 1;
	localparam int EV_KEY_BAD = 2;

	typedef enum logic [2:0] {
		UNL_LOCKED = 3'b001,
		UNL_KEY1 = 3'b010,
		UNL_OPEN = 3'b100
	} wdcrf_unlock_t;

	typedef enum logic [1:0] {
		WDP_RUN = 2'b01,
		WDP_PEND = 2'b10
	} wdcrf_phase_t;

	typedef struct packed {
		logic power_on_flag;
		logic watchdog_irq_flag;
		logic watchdog_reset_flag;
		logic watchdog_reset_enable;
		logic watchdog_restart;
		logic watchdog_irq_enable;
		logic watchdog_irq_priority;
		logic [1:0] interval_sel;
		logic [5:0] clk_ctrl_low;
		logic [CNT_W-1:0] wdt_count;
		logic [DELAY_W-1:0] delay_count;
		wdcrf_phase_t phase;
		wdcrf_unlock_t unlock;
		logic [OPEN_W-1:0] open_count;
		logic [EV_W-1:0] irq_status;
		logic [EV_W-1:0] irq_mask;
		logic [7:0] read_data;
		logic chip_reset;
	} wdcrf_state_t;
endpackage : wdcrf_pkg

// ===== logic/wdcrf_top.sv
// Watchdog control, reset flags, unlock sequence and interrupt enables
`timescale 1ns/100ps
module wdcrf_top #(
	parameter int unsigned SEL0_BITS = 17,
	parameter int unsigned SEL1_BITS = 20,
	parameter int unsigned SEL2_BITS = 23,
	parameter int unsigned SEL3_BITS = 26
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ext_reset,
	input wire logic power_fail,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic wdt_irq_req,
	output logic wdt_irq_priority,
	output logic wdt_chip_reset,
	output logic irq
);
	import wdcrf_pkg::*;

	wdcrf_state_t s;
	wdcrf_state_t next_s;
	logic [CNT_W-1:0] next_count;
	logic timeout_now;
	logic wr_ctrl;
	logic wr_unlock;
	logic prot_ok;
	logic [EV_W-1:0] ev;

	// Width of the active interval; used for both the old and new count
	function automatic int unsigned sel_bits(input logic [1:0] sel);
		case (sel)
			2'b00: sel_bits = SEL0_BITS;
			2'b01: sel_bits = SEL1_BITS;
			2'b10: sel_bits = SEL2_BITS;
			default: sel_bits = SEL3_BITS;
		endcase
	endfunction : sel_bits

	function automatic logic top_bit(input logic [CNT_W-1:0] c, input logic [1:0] sel);
		top_bit = c[sel_bits(sel) - 1];
	endfunction : top_bit

	assign next_count = s.wdt_count + 1'b1;
	// Carry out of the selected bit marks the end of the interval
	assign timeout_now = !s.watchdog_restart && top_bit(s.wdt_count, s.interval_sel)
		&& !top_bit(next_count, s.interval_sel);
	assign wr_ctrl = reg_wr && (reg_addr == ADDR_WD_CTRL);
	assign wr_unlock = reg_wr && (reg_addr == ADDR_UNLOCK);
	assign prot_ok = (s.unlock == UNL_OPEN);

	always_comb begin
		next_s = s;
		next_s.chip_reset = 1'b0;
		next_s.read_data = 8'h00;
		ev = '0;

		// Key window ageing; the window also bounds the gap between the two keys
		case (s.unlock)
			UNL_LOCKED: begin
				next_s.open_count = '0;
			end
			UNL_KEY1, UNL_OPEN: begin
				if (s.open_count == '0) begin
					next_s.unlock = UNL_LOCKED;
				end else begin
					next_s.open_count = s.open_count - 1'b1;
				end
			end
			default: begin
				next_s.unlock = UNL_LOCKED;
			end
		endcase

		if (wr_unlock) begin
			if (reg_wdata == KEY_FIRST) begin
				next_s.unlock = UNL_KEY1;
				next_s.open_count = UNLOCK_OPEN_CLKS - 1'b1;
			end else if (s.unlock == UNL_KEY1 && reg_wdata == KEY_SECOND) begin
				next_s.unlock = UNL_OPEN;
				next_s.open_count = UNLOCK_OPEN_CLKS - 1'b1;
			end else begin
				next_s.unlock = UNL_LOCKED;
				ev[EV_KEY_BAD] = 1'b1;
			end
		end

		if (wr_ctrl) begin
			next_s.watchdog_reset_flag = reg_wdata[BIT_RST_FLAG];
			if (prot_ok) begin
				next_s.power_on_flag = reg_wdata[BIT_POWER_ON];
				next_s.watchdog_irq_flag = reg_wdata[BIT_IRQ_FLAG];
				next_s.watchdog_reset_enable = reg_wdata[BIT_RST_EN];
				next_s.watchdog_restart = reg_wdata[BIT_RESTART];
				// One protected write per unlock keeps a stray second write out
				next_s.unlock = UNL_LOCKED;
			end
		end
		if (reg_wr && reg_addr == ADDR_EXT_IRQ_EN) begin
			next_s.watchdog_irq_enable = reg_wdata[BIT_WD_IRQ_EN];
		end
		if (reg_wr && reg_addr == ADDR_EXT_IRQ_PRI) begin
			next_s.watchdog_irq_priority = reg_wdata[BIT_WD_IRQ_PRI];
		end
		if (reg_wr && reg_addr == ADDR_CLK_CTRL) begin
			next_s.interval_sel = reg_wdata[BIT_SEL_LO +: 2];
			next_s.clk_ctrl_low = reg_wdata[5:0];
		end
		if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
			next_s.irq_mask = reg_wdata[EV_W-1:0];
		end
		if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
			next_s.irq_status = s.irq_status & ~reg_wdata[EV_W-1:0];
		end

		// Counter and time-out sequence; hardware sets below win over writes
		if (s.watchdog_restart) begin
			next_s.wdt_count = '0;
			next_s.watchdog_restart = 1'b0;
			next_s.phase = WDP_RUN;
			next_s.delay_count = '0;
		end else begin
			next_s.wdt_count = next_count;
			case (s.phase)
				WDP_RUN: begin
					if (timeout_now) begin
						next_s.watchdog_irq_flag = 1'b1;
						ev[EV_TIMEOUT] = 1'b1;
						if (s.watchdog_reset_enable) begin
							next_s.phase = WDP_PEND;
							next_s.delay_count = RESET_DELAY_CLKS - 1'b1;
						end
					end
				end
				WDP_PEND: begin
					// Short intervals can expire again while the reset is still pending
					if (timeout_now) begin
						next_s.watchdog_irq_flag = 1'b1;
						ev[EV_TIMEOUT] = 1'b1;
					end
					if (!s.watchdog_reset_enable) begin
						next_s.phase = WDP_RUN;
					end else if (s.delay_count == '0) begin
						next_s.chip_reset = 1'b1;
						next_s.watchdog_reset_flag = 1'b1;
						next_s.watchdog_irq_flag = 1'b0;
						next_s.watchdog_restart = 1'b0;
						next_s.watchdog_irq_enable = 1'b0;
						next_s.watchdog_irq_priority = 1'b0;
						next_s.interval_sel = SEL_RESET;
						next_s.clk_ctrl_low = CLK_CTRL_LOW_RESET;
						next_s.wdt_count = '0;
						next_s.unlock = UNL_LOCKED;
						next_s.phase = WDP_RUN;
						ev[EV_CHIP_RST] = 1'b1;
					end else begin
						next_s.delay_count = s.delay_count - 1'b1;
					end
				end
				default: begin
					next_s.phase = WDP_RUN;
				end
			endcase
		end

		// External and power-fail resets; power-on flag and enable survive both
		if (ext_reset || power_fail) begin
			next_s.watchdog_irq_flag = 1'b0;
			next_s.watchdog_restart = 1'b0;
			next_s.watchdog_irq_enable = 1'b0;
			next_s.watchdog_irq_priority = 1'b0;
			next_s.interval_sel = SEL_RESET;
			next_s.clk_ctrl_low = CLK_CTRL_LOW_RESET;
			next_s.wdt_count = '0;
			next_s.delay_count = '0;
			next_s.phase = WDP_RUN;
			next_s.unlock = UNL_LOCKED;
			next_s.chip_reset = 1'b0;
			next_s.watchdog_reset_flag = s.watchdog_reset_flag;
			next_s.watchdog_reset_enable = s.watchdog_reset_enable;
			next_s.power_on_flag = s.power_on_flag;
			if (power_fail) begin
				next_s.watchdog_reset_flag = 1'b0;
			end
		end

		next_s.irq_status = next_s.irq_status | ev;

		if (reg_rd) begin
			case (reg_addr)
				ADDR_WD_CTRL: begin
					next_s.read_data[BIT_POWER_ON] = s.power_on_flag;
					next_s.read_data[BIT_IRQ_FLAG] = s.watchdog_irq_flag;
					next_s.read_data[BIT_RST_FLAG] = s.watchdog_reset_flag;
					next_s.read_data[BIT_RST_EN] = s.watchdog_reset_enable;
					next_s.read_data[BIT_RESTART] = s.watchdog_restart;
				end
				ADDR_EXT_IRQ_EN: begin
					next_s.read_data[7:5] = EIE_RSVD_ONES;
					next_s.read_data[BIT_WD_IRQ_EN] = s.watchdog_irq_enable;
				end
				ADDR_EXT_IRQ_PRI: begin
					next_s.read_data[BIT_WD_IRQ_PRI] = s.watchdog_irq_priority;
				end
				ADDR_CLK_CTRL: begin
					next_s.read_data = {s.interval_sel, s.clk_ctrl_low};
				end
				ADDR_IRQ_STATUS: begin
					next_s.read_data[EV_W-1:0] = s.irq_status;
				end
				ADDR_IRQ_MASK: begin
					next_s.read_data[EV_W-1:0] = s.irq_mask;
				end
				default: begin
					next_s.read_data = 8'h00;
				end
			endcase
		end
	end

	// Only power-up reaches rst_n: it alone sets the power-on flag and clears the enable
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.power_on_flag <= 1'b1;
			s.watchdog_reset_enable <= 1'b0;
			s.watchdog_reset_flag <= 1'b0;
			s.clk_ctrl_low <= CLK_CTRL_LOW_RESET;
			s.phase <= WDP_RUN;
			s.unlock <= UNL_LOCKED;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.read_data;
	assign wdt_irq_req = s.watchdog_irq_flag && s.watchdog_irq_enable;
	assign wdt_irq_priority = s.watchdog_irq_priority;
	assign wdt_chip_reset = s.chip_reset;
	assign irq = |(s.irq_status & s.irq_mask);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_power_on_hold;
		s.power_on_flag && !(wr_ctrl && prot_ok) |=> s.power_on_flag;
	endproperty
	a_power_on_hold: assert property (p_power_on_hold) else $error("power-on flag lost");

	property p_timeout_flag;
		timeout_now && !ext_reset && !power_fail && !next_s.chip_reset |=> s.watchdog_irq_flag;
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) else $error("time-out flag not set");

	property p_chip_reset_flag;
		s.chip_reset |-> s.watchdog_reset_flag && !s.watchdog_irq_flag && s.wdt_count == '0;
	endproperty
	a_chip_reset_flag: assert property (p_chip_reset_flag) else $error("reset flag missing");

	property p_flag_quiet;
		!s.watchdog_reset_enable && !wr_ctrl && !power_fail |=> $stable(s.watchdog_reset_flag);
	endproperty
	a_flag_quiet: assert property (p_flag_quiet) else $error("reset flag moved while disabled");

	property p_power_fail_clear;
		power_fail |=> !s.watchdog_reset_flag && !s.watchdog_irq_flag;
	endproperty
	a_power_fail_clear: assert property (p_power_fail_clear) else $error("power-fail kept flag");

	property p_ext_reset_keep;
		ext_reset && !power_fail |=> s.watchdog_reset_flag == $past(s.watchdog_reset_flag)
			&& s.watchdog_reset_enable == $past(s.watchdog_reset_enable)
			&& s.power_on_flag == $past(s.power_on_flag) && !s.watchdog_irq_flag
			&& !s.watchdog_restart;
	endproperty
	a_ext_reset_keep: assert property (p_ext_reset_keep) else $error("external reset pattern");

	property p_arm_enable;
		wr_ctrl && prot_ok && reg_wdata[BIT_RST_EN] |=> s.watchdog_reset_enable;
	endproperty
	a_arm_enable: assert property (p_arm_enable) else $error("enable not armed");

	property p_restart_clear;
		s.watchdog_restart |=> !s.watchdog_restart && s.wdt_count == '0 && s.phase == WDP_RUN;
	endproperty
	a_restart_clear: assert property (p_restart_clear) else $error("restart did not clear");

	property p_pend_load;
		s.phase == WDP_RUN ##1 s.phase == WDP_PEND |-> s.delay_count == RESET_DELAY_CLKS - 1'b1;
	endproperty
	a_pend_load: assert property (p_pend_load) else $error("reset delay not 512");

	property p_pend_fire;
		s.phase == WDP_PEND && s.delay_count == '0 && s.watchdog_reset_enable && !ext_reset
			&& !power_fail && !s.watchdog_restart |=> s.chip_reset ##1 !s.chip_reset;
	endproperty
	a_pend_fire: assert property (p_pend_fire) else $error("chip reset not issued");

	property p_locked_write;
		wr_ctrl && !prot_ok |=> s.watchdog_reset_enable == $past(s.watchdog_reset_enable);
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("protected bit written");

	property p_bad_key;
		wr_unlock && reg_wdata != KEY_FIRST && !(s.unlock == UNL_KEY1 && reg_wdata == KEY_SECOND)
			|=> s.unlock == UNL_LOCKED && s.irq_status[EV_KEY_BAD];
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("bad key kept unlock");

	property p_window_close;
		s.unlock == UNL_OPEN && s.open_count == '0 && !(wr_unlock && reg_wdata == KEY_FIRST)
			|=> s.unlock == UNL_LOCKED;
	endproperty
	a_window_close: assert property (p_window_close) else $error("unlock window overran");

	property p_eie_read;
		reg_rd && reg_addr == ADDR_EXT_IRQ_EN
			|=> reg_rdata == {EIE_RSVD_ONES, $past(s.watchdog_irq_enable), 4'h0};
	endproperty
	a_eie_read: assert property (p_eie_read) else $error("enable readback wrong");

	property p_eip_write;
		reg_wr && reg_addr == ADDR_EXT_IRQ_PRI && !ext_reset && !power_fail && !next_s.chip_reset
			|=> wdt_irq_priority == $past(reg_wdata[BIT_WD_IRQ_PRI]);
	endproperty
	a_eip_write: assert property (p_eip_write) else $error("priority not stored");

	property p_long_interval;
		timeout_now && s.interval_sel == 2'b11 |-> &s.wdt_count[SEL3_BITS-1:0];
	endproperty
	a_long_interval: assert property (p_long_interval) else $error("longest interval wrong");

	property p_irq_flag_hold;
		s.watchdog_irq_flag && !(wr_ctrl && prot_ok) && !ext_reset && !power_fail
			&& !next_s.chip_reset |=> s.watchdog_irq_flag;
	endproperty
	a_irq_flag_hold: assert property (p_irq_flag_hold) else $error("irq flag dropped");

	property p_pend_cancel;
		s.phase == WDP_PEND && !s.watchdog_reset_enable |=> s.phase == WDP_RUN && !s.chip_reset;
	endproperty
	a_pend_cancel: assert property (p_pend_cancel) else $error("disabled reset kept");

	property p_keep_enable;
		ext_reset || power_fail |=> s.watchdog_reset_enable == $past(s.watchdog_reset_enable);
	endproperty
	a_keep_enable: assert property (p_keep_enable) else $error("reset enable changed");

	property p_reset_pulse;
		s.chip_reset |=> !s.chip_reset;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("chip reset too long");

	property p_ext_cancel;
		ext_reset || power_fail |=> s.phase == WDP_RUN && !s.chip_reset && s.wdt_count == '0
			&& s.unlock == UNL_LOCKED;
	endproperty
	a_ext_cancel: assert property (p_ext_cancel) else $error("reset left work pending");

	property p_ctrl_read;
		reg_rd && reg_addr == ADDR_WD_CTRL
			|=> reg_rdata[BIT_RST_FLAG] == $past(s.watchdog_reset_flag)
			&& reg_rdata[BIT_RST_EN] == $past(s.watchdog_reset_enable)
			&& reg_rdata[BIT_POWER_ON] == $past(s.power_on_flag);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	property p_read_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not cleared");

	property p_enable_write;
		reg_wr && reg_addr == ADDR_EXT_IRQ_EN && !ext_reset && !power_fail && !next_s.chip_reset
			|=> s.watchdog_irq_enable == $past(reg_wdata[BIT_WD_IRQ_EN]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("irq enable not stored");

	property p_count_step;
		rst_n && !s.watchdog_restart && !ext_reset && !power_fail && !next_s.chip_reset
			|=> s.wdt_count == $past(s.wdt_count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter skipped");

	property p_key_open;
		wr_unlock && s.unlock == UNL_KEY1 && reg_wdata == KEY_SECOND && !ext_reset
			&& !power_fail && !next_s.chip_reset
			|=> s.unlock == UNL_OPEN && s.open_count == UNLOCK_OPEN_CLKS - 1'b1;
	endproperty
	a_key_open: assert property (p_key_open) else $error("second key did not open");
endmodule : wdcrf_top

// ===== test/wdcrf_top_tb_top.sv
// Self-checking bench for the watchdog supervision block
`timescale 1ns/100ps
module wdcrf_top_tb_top;
	import wdcrf_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ext_reset = 1'b0;
	logic power_fail = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic wdt_irq_req;
	logic wdt_irq_priority;
	logic wdt_chip_reset;
	logic irq;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [7:0] v;
	int fail_count = 0;
	int checks_done = 0;
	int pulses = 0;
	int n = 0;
	integer seed = 32'hf0ea;

	always #2 clk_sys = ~clk_sys;

	// Short intervals 16/32/64/128 clocks keep the run brief
	wdcrf_top #(.SEL0_BITS(4), .SEL1_BITS(5), .SEL2_BITS(6), .SEL3_BITS(7)) u_dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ext_reset(ext_reset),
		.power_fail(power_fail),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.wdt_irq_req(wdt_irq_req),
		.wdt_irq_priority(wdt_irq_priority),
		.wdt_chip_reset(wdt_chip_reset),
		.irq(irq)
	);

	task chk(input logic [7:0] seen, input logic [7:0] expd);
		checks_done++;
		if (seen !== expd) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, expd);
		end
	endtask : chk

	// The wr and rd tasks start right after a rising edge and leave the strobe up for chaining; idle drops it
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge clk_sys);
	endtask : rd

	task idle;
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : idle

	task unlock;
		wr(ADDR_UNLOCK, KEY_FIRST);
		wr(ADDR_UNLOCK, KEY_SECOND);
	endtask : unlock

	// Counts falling edges until the chosen output is high, bounded against a hang
	task wait_sig(input bit sel, output int cnt);
		cnt = 0;
		@(negedge clk_sys);
		while ((sel ? wdt_chip_reset : wdt_irq_req) !== 1'b1 && cnt < 2000) begin
			cnt++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
	endtask : wait_sig

	task test_end(input string name);
		$display("test %s finished", name);
	endtask : test_end

	task test_done;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// Read data stands only in the cycle after the strobe, so it is judged there
	always @(posedge clk_sys) begin
		rd_seen <= reg_rd;
	end

	always @(negedge clk_sys) begin
		if (wdt_chip_reset === 1'b1) pulses++;
		if (rd_seen && exp_q.size() > 0) chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
	end

	initial begin
		#40000;
		fail_count++;
		$display("unexpected at %0t: run timed out", $time);
		test_done();
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(ADDR_WD_CTRL, 8'h40, 8'hFF);
		rd(ADDR_IRQ_STATUS, 8'h00, 8'hFF);
		rd(ADDR_EXT_IRQ_EN, 8'hE0, 8'hFF);
		rd(ADDR_EXT_IRQ_PRI, 8'h00, 8'hFF);
		rd(ADDR_CLK_CTRL, 8'h01, 8'hFF);
		rd(ADDR_UNLOCK, 8'h00, 8'hFF);
		rd(8'h33, 8'h00, 8'hFF);
		wr(ADDR_WD_CTRL, 8'h0F);
		rd(ADDR_WD_CTRL, 8'h44, 8'hF7);
		wr(ADDR_WD_CTRL, 8'h00);
		rd(ADDR_WD_CTRL, 8'h40, 8'hF7);
		idle();
		test_end("reset_and_access");
		repeat (600) @(posedge clk_sys);
		rd(ADDR_WD_CTRL, 8'h48, 8'hFF);
		idle();
		chk(8'(pulses), 8'h00);
		test_end("timeout_without_reset");
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(ADDR_EXT_IRQ_PRI, v);
			wr(ADDR_EXT_IRQ_EN, v);
			rd(ADDR_EXT_IRQ_PRI, v & 8'h10, 8'hFF);
			rd(ADDR_EXT_IRQ_EN, (v & 8'h10) | 8'hE0, 8'hFF);
			idle();
			@(negedge clk_sys);
			chk({7'h00, wdt_irq_priority}, {7'h00, v[4]});
			chk({7'h00, wdt_irq_req}, {7'h00, v[4]});
			@(posedge clk_sys);
		end
		test_end("irq_enable_priority");
		wr(ADDR_IRQ_STATUS, 8'h07);
		wr(ADDR_UNLOCK, 8'h12);
		idle();
		rd(ADDR_IRQ_STATUS, 8'h04, 8'h06);
		wr(ADDR_IRQ_MASK, 8'h04);
		idle();
		@(negedge clk_sys);
		chk({7'h00, irq}, 8'h01);
		@(posedge clk_sys);
		wr(ADDR_IRQ_STATUS, 8'h04);
		idle();
		@(negedge clk_sys);
		chk({7'h00, irq}, 8'h00);
		@(posedge clk_sys);
		wr(ADDR_IRQ_MASK, 8'h00);
		test_end("bad_key_event");
		unlock();
		wr(ADDR_WD_CTRL, 8'h01);
		unlock();
		wr(ADDR_WD_CTRL, 8'h03);
		wr(ADDR_EXT_IRQ_EN, 8'h10);
		idle();
		wait_sig(1'b0, n);
		chk(8'(n >= 14 && n <= 18), 8'h01);
		wait_sig(1'b1, n);
		chk(8'(n == 511), 8'h01);
		rd(ADDR_WD_CTRL, 8'h06, 8'hF7);
		rd(ADDR_EXT_IRQ_EN, 8'hE0, 8'hFF);
		rd(ADDR_IRQ_STATUS, 8'h02, 8'h02);
		idle();
		test_end("chip_reset_delay");
		// A restart every few clocks must keep the counter from ever expiring
		for (int i = 0; i < 40; i++) begin
			unlock();
			wr(ADDR_WD_CTRL, 8'h07);
		end
		idle();
		rd(ADDR_WD_CTRL, 8'h06, 8'hFF);
		idle();
		chk(8'(pulses), 8'h01);
		test_end("restart");
		ext_reset <= 1'b1;
		@(posedge clk_sys);
		ext_reset <= 1'b0;
		rd(ADDR_WD_CTRL, 8'h06, 8'hF7);
		rd(ADDR_CLK_CTRL, 8'h01, 8'hFF);
		wr(ADDR_CLK_CTRL, 8'hC0);
		wr(ADDR_EXT_IRQ_EN, 8'h10);
		rd(ADDR_CLK_CTRL, 8'hC0, 8'hFF);
		unlock();
		wr(ADDR_WD_CTRL, 8'h01);
		idle();
		wait_sig(1'b0, n);
		chk(8'(n >= 124 && n <= 132), 8'h01);
		test_end("external_reset_interval");
		// Middle interval selections, timed from the restart like the longest one
		for (int i = 1; i < 3; i++) begin
			wr(ADDR_CLK_CTRL, 8'(i << 6));
			unlock();
			wr(ADDR_WD_CTRL, 8'h01);
			idle();
			wait_sig(1'b0, n);
			chk(8'(n), 8'(16 << i));
		end
		test_end("middle_intervals");
		unlock();
		wr(ADDR_WD_CTRL, 8'h06);
		idle();
		power_fail <= 1'b1;
		@(posedge clk_sys);
		power_fail <= 1'b0;
		rd(ADDR_WD_CTRL, 8'h02, 8'hF7);
		idle();
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(ADDR_WD_CTRL, 8'h40, 8'hFF);
		idle();
		idle();
		test_end("power_resets");
		test_done();
	end
endmodule : wdcrf_top_tb_top
